// ==== hw/ccsr_pkg.sv ====
// Package of the configuration CRC signature readout block.
// Assumes one device clock; all slower rates are enable pulses.

package ccsr_pkg;

  // ----------------------------------------------------------------
  // Widths and defaults
  // ----------------------------------------------------------------
  localparam int CCSR_SIG_W = 32;
  localparam int CCSR_WORD_W_DEF = 16;
  localparam int CCSR_FRAME_WORDS_DEF = 64;
  // Engine clock = oscillator / 2^n; n = 1 divides by two
  localparam int CCSR_DIV_LOG2_DEF = 1;
  // Nominal oscillator rate in MHz (ref_clk stands in for it)
  localparam int CCSR_OSC_MHZ = 80;
  localparam logic [CCSR_SIG_W-1:0] CCSR_POLY_DEF = 32'h04c11db7;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [CCSR_SIG_W-1:0] CCSR_SIG_RST = 32'h00000000;
  localparam logic [CCSR_SIG_W-1:0] CCSR_CRC_SEED = 32'hffffffff;
  localparam logic CCSR_ERR_RST = 1'h0;
  localparam logic CCSR_PIN_IDLE = 1'h0;
  localparam logic CCSR_RECONF_IDLE = 1'h1;

  // ----------------------------------------------------------------
  // Readout controls from user logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic shiftNotLoad;
    logic loadSource;
  } ccsr_ctrl_t;

  localparam ccsr_ctrl_t CCSR_CTRL_RST = '{shiftNotLoad: 1'h1,
                                          loadSource: 1'h0};

endpackage : ccsr_pkg

// ==== hw/ccsr_clk_div.sv ====
// Power-of-two divider giving the error detection engine enable.
// Assumes a free-running clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module ccsr_clk_div
  import ccsr_pkg::*;
#(
  parameter int DIV_LOG2 = CCSR_DIV_LOG2_DEF
) (
  input wire logic ref_clk,
  input wire logic reset,
  output logic engineEn
);

  localparam int CW = (DIV_LOG2 > 0) ? DIV_LOG2 : 1;

  logic [CW-1:0] divCnt_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + CW'(1);
    end
  end

  // One pulse every 2^n cycles
  assign engineEn = (DIV_LOG2 == 0) ? 1'b1 : (&divCnt_q);

  a_div_spacing: assert property (@(posedge ref_clk) disable iff (reset)
    (DIV_LOG2 > 0 && engineEn) |=> !engineEn)
    else $error("engine enable not divided");

endmodule : ccsr_clk_div

`default_nettype wire

// ==== hw/ccsr_readout.sv ====
// Configuration CRC signature engine with its user readout port.
// Behaviour
// - The computed 32-bit signature is held in its own register.
// - Readout loads and shifts happen only on a rising readout clock.
// - With shift selected, each rising readout clock moves one bit out.
// - With load selected and source low, the expected CRC is loaded.
// - Load with source high takes the calculated signature.
// - The source select is ignored while shifting.
// - The error flag is timed by the oscillator, not the readout clock.
// - The error flag rises when the calculated CRC differs from expected.
// - A one-cycle pass-done pulse marks each completed detection pass.
// - After reconfiguration the block runs correctly unaided.
// - The engine runs on the oscillator divided by a power of two.
// Assumes ref_clk is the internal oscillator; cfgWord answers cfgAddr
// combinationally on the same clock; readout pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module ccsr_readout
  import ccsr_pkg::*;
#(
  parameter int WORD_W = CCSR_WORD_W_DEF,
  parameter int FRAME_WORDS = CCSR_FRAME_WORDS_DEF,
  parameter int DIV_LOG2 = CCSR_DIV_LOG2_DEF,
  parameter logic [CCSR_SIG_W-1:0] POLY = CCSR_POLY_DEF,
  localparam int ADDR_W = (FRAME_WORDS > 1) ? $clog2(FRAME_WORDS) : 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  output logic [ADDR_W-1:0] cfgAddr,
  input wire logic [WORD_W-1:0] cfgWord,
  input wire logic [CCSR_SIG_W-1:0] expectedCrc,
  input wire logic readClk,
  input wire ccsr_ctrl_t readCtrl,
  output logic regOut,
  output logic crcError,
  output logic passDone,
  input wire logic reconfig_request_n
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic rdSync1_q, rdSync2_q, rdSync3_q;
  ccsr_ctrl_t ctrlSync1_q, ctrlSync2_q;
  logic rcfSync1_q, rcfSync2_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdSync1_q <= CCSR_PIN_IDLE;
      rdSync2_q <= CCSR_PIN_IDLE;
      rdSync3_q <= CCSR_PIN_IDLE;
      ctrlSync1_q <= CCSR_CTRL_RST;
      ctrlSync2_q <= CCSR_CTRL_RST;
      rcfSync1_q <= CCSR_RECONF_IDLE;
      rcfSync2_q <= CCSR_RECONF_IDLE;
    end else begin
      rdSync1_q <= readClk;
      rdSync2_q <= rdSync1_q;
      rdSync3_q <= rdSync2_q;
      ctrlSync1_q <= readCtrl;
      ctrlSync2_q <= ctrlSync1_q;
      rcfSync1_q <= reconfig_request_n;
      rcfSync2_q <= rcfSync1_q;
    end
  end

  // Controls travel the same depth as the clock so they stay aligned
  logic readEdge;
  logic reconfigActive;
  assign readEdge = rdSync2_q & ~rdSync3_q;
  assign reconfigActive = ~rcfSync2_q;

  // ----------------------------------------------------------------
  // Detection engine
  // ----------------------------------------------------------------
  function automatic logic [CCSR_SIG_W-1:0] crc_step(
    input logic [CCSR_SIG_W-1:0] crcIn,
    input logic [WORD_W-1:0] data
  );
    logic [CCSR_SIG_W-1:0] c;
    logic fb;
    c = crcIn;
    fb = 1'b0;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      fb = c[CCSR_SIG_W-1] ^ data[i];
      c = {c[CCSR_SIG_W-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
    return c;
  endfunction : crc_step

  logic engineEn;

  ccsr_clk_div #(.DIV_LOG2(DIV_LOG2)) u_div (
    .ref_clk(ref_clk),
    .reset(reset),
    .engineEn(engineEn)
  );

  logic [ADDR_W-1:0] addr_q;
  logic [CCSR_SIG_W-1:0] crcAcc_q, crcNext;
  logic [CCSR_SIG_W-1:0] signature_q;
  logic lastWord, passEnd, mismatch;
  logic error_q, done_q;

  assign crcNext = crc_step(crcAcc_q, cfgWord);
  assign lastWord = (addr_q == ADDR_W'(FRAME_WORDS - 1));
  assign passEnd = engineEn & lastWord & ~reconfigActive;
  assign mismatch = (crcNext != expectedCrc);
  assign cfgAddr = addr_q;

  // Reconfiguration holds the engine at the start of a pass, so a
  // repaired memory is rescanned from word 0 without other action
  always_ff @(posedge ref_clk) begin
    if (reset || reconfigActive) begin
      addr_q <= '0;
      crcAcc_q <= CCSR_CRC_SEED;
    end else if (engineEn) begin
      addr_q <= lastWord ? '0 : addr_q + ADDR_W'(1);
      crcAcc_q <= lastWord ? CCSR_CRC_SEED : crcNext;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      signature_q <= CCSR_SIG_RST;
    end else if (passEnd) begin
      signature_q <= crcNext;
    end
  end

  // Flag is sticky: only reset and reconfiguration clear it, and a pass cannot
  // end while the request is low, so no set is lost to the clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      error_q <= CCSR_ERR_RST;
      done_q <= 1'b0;
    end else begin
      if (passEnd && mismatch) begin
        error_q <= 1'b1;
      end else if (reconfigActive) begin
        error_q <= CCSR_ERR_RST;
      end
      done_q <= passEnd;
    end
  end

  assign crcError = error_q;
  assign passDone = done_q;

  // ----------------------------------------------------------------
  // Readout shift register
  // ----------------------------------------------------------------
  logic [CCSR_SIG_W-1:0] shift_q, shift_d, loadVal;

  assign loadVal = ctrlSync2_q.loadSource ? signature_q
                                          : expectedCrc;
  // Shift takes priority; source select is a don't-care then
  assign shift_d = ctrlSync2_q.shiftNotLoad
                 ? {1'b0, shift_q[CCSR_SIG_W-1:1]}
                 : loadVal;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shift_q <= CCSR_SIG_RST;
    end else if (readEdge) begin
      shift_q <= shift_d;
    end
  end

  // Bit 0 is visible right after a load
  assign regOut = shift_q[0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_shift_only_edge: assert property (@(posedge ref_clk) disable iff (reset)
    !readEdge |=> $stable(shift_q))
    else $error("readout register changed without readout edge");

  a_shift_advance: assert property (@(posedge ref_clk) disable iff (reset)
    (readEdge && ctrlSync2_q.shiftNotLoad)
      |=> shift_q == {1'b0, $past(shift_q[CCSR_SIG_W-1:1])})
    else $error("shift did not advance one bit");

  a_load_expected: assert property (@(posedge ref_clk) disable iff (reset)
    (readEdge && !ctrlSync2_q.shiftNotLoad && !ctrlSync2_q.loadSource)
      |=> shift_q == $past(expectedCrc))
    else $error("expected CRC not loaded");

  a_load_signature: assert property (@(posedge ref_clk) disable iff (reset)
    (readEdge && !ctrlSync2_q.shiftNotLoad && ctrlSync2_q.loadSource)
      |=> shift_q == $past(signature_q))
    else $error("signature not loaded");

  a_source_ignored: assert property (@(posedge ref_clk) disable iff (reset)
    (readEdge && ctrlSync2_q.shiftNotLoad && ctrlSync2_q.loadSource)
      |=> shift_q == {1'b0, $past(shift_q[CCSR_SIG_W-1:1])})
    else $error("load happened while shifting");

  a_first_bit: assert property (@(posedge ref_clk) disable iff (reset)
    (readEdge && !ctrlSync2_q.shiftNotLoad)
      |=> regOut == $past(loadVal[0]) ##1 regOut == $past(regOut, 1)
          || readEdge)
    else $error("first bit not presented after load");

  a_error_set: assert property (@(posedge ref_clk) disable iff (reset)
    (passEnd && mismatch) |=> crcError && passDone)
    else $error("mismatch did not raise error flag");

  a_error_on_pass: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(crcError) |-> passDone)
    else $error("error flag rose outside a pass end");

  a_done_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    passDone |=> !passDone)
    else $error("pass done longer than one cycle");

  a_reconfig_clear: assert property (@(posedge ref_clk) disable iff (reset)
    reconfigActive |=> !crcError && addr_q == '0)
    else $error("reconfiguration did not restart engine");

  a_sig_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !passEnd |=> $stable(signature_q))
    else $error("signature changed outside pass end");

  c_error_seen: cover property (@(posedge ref_clk) disable iff (reset)
    $rose(crcError));
  c_clean_pass: cover property (@(posedge ref_clk) disable iff (reset)
    passDone && !crcError);
  c_load_then_shift: cover property (@(posedge ref_clk) disable iff (reset)
    (readEdge && !ctrlSync2_q.shiftNotLoad) ##[1:20]
    (readEdge && ctrlSync2_q.shiftNotLoad));
  c_recover: cover property (@(posedge ref_clk) disable iff (reset)
    crcError ##1 reconfigActive ##[1:50] !crcError);

endmodule : ccsr_readout

`default_nettype wire

// ==== dv/ccsr_core_model.sv ====
// Core-side model: configuration words for the scan and the error pin.
// Assumes the engine address is answered within the same cycle.
`timescale 1ns/1ps
`default_nettype none

module ccsr_core_model
  import ccsr_pkg::*;
#(
  parameter int ADDR_W = 2,
  parameter int WORD_W = 16
) (
  input wire logic [ADDR_W-1:0] cfgAddr,
  input wire logic flip,
  output logic [WORD_W-1:0] cfgWord,
  input wire logic crcError,
  output logic errSeen
);
  // -------------------------------------------------------------
  // Configuration words
  // -------------------------------------------------------------
  // Bit 0 of word zero can be upset to play a single-event flip
  logic upset;
  logic errPinOe;
  assign upset = flip && (cfgAddr == '0);
  assign cfgWord = (16'ha5c3 + WORD_W'(cfgAddr) * 16'h0f1e) ^ WORD_W'(upset);
  // -------------------------------------------------------------
  // Error pin
  // -------------------------------------------------------------
  // Bidirectional pin with its enable held on, so the core reads it back
  assign errPinOe = 1'h1;
  assign errSeen = errPinOe ? crcError : 1'h0;
endmodule : ccsr_core_model

`default_nettype wire

// ==== dv/config_crc_signature_readout_test.sv ====
// Self-checking bench of the signature readout block.
// Assumes the package, the design and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin \
  n_errors++; $display("MISMATCH %0t %s", $time, m); end end

module config_crc_signature_readout_test
  import ccsr_pkg::*;
;
  // -------------------------------------------------------------
  // Signals and instances
  // -------------------------------------------------------------
  // A short frame keeps each pass at eight cycles
  localparam int FW = 4;
  localparam int DL = 1;
  localparam int PASS = FW << DL;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic [1:0] cfgAddr;
  logic [15:0] cfgWord;
  logic [31:0] expectedCrc;
  logic readClk, regOut, crcError, passDone, reconfigReqN, flip, errSeen;
  ccsr_ctrl_t readCtrl;
  int n_errors = 0;
  int n_tests = 0;
  int k;

  always #25 ref_clk = ~ref_clk;

  ccsr_readout #(.FRAME_WORDS(FW), .DIV_LOG2(DL)) DUT (
    .ref_clk(ref_clk), .reset(reset), .cfgAddr(cfgAddr),
    .cfgWord(cfgWord), .expectedCrc(expectedCrc), .readClk(readClk),
    .readCtrl(readCtrl), .regOut(regOut), .crcError(crcError),
    .passDone(passDone), .reconfig_request_n(reconfigReqN));

  ccsr_core_model #(.ADDR_W(2), .WORD_W(16)) core (
    .cfgAddr(cfgAddr), .flip(flip), .cfgWord(cfgWord),
    .crcError(crcError), .errSeen(errSeen));

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] sigOf(input logic flipped);
    logic [31:0] c;
    logic [15:0] w;
    c = CCSR_CRC_SEED;
    for (int a = 0; a < FW; a++) begin
      w = 16'ha5c3 + 16'(a) * 16'h0f1e;
      if (flipped && a == 0) w[0] = ~w[0];
      for (int b = 15; b >= 0; b--) begin
        c = (c[31] ^ w[b]) ? ((c << 1) ^ CCSR_POLY_DEF) : (c << 1);
      end
    end
    return c;
  endfunction : sigOf

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : step

  // Controls settle three cycles before the rise, as the pins are synced
  task automatic pulse(input logic shift, input logic src);
    readCtrl = '{shiftNotLoad: shift, loadSource: src};
    step(3);
    readClk = 1'h1;
    step(4);
    readClk = 1'h0;
    step(4);
  endtask : pulse

  task automatic waitFor(input bit err, output int n);
    n = 0;
    do begin
      step(1);
      n++;
    end while ((err ? errSeen : passDone) !== 1'h1 && n < 4 * PASS);
  endtask : waitFor

  task automatic readSig(input logic src, input logic [31:0] exp,
                         input bit idle, input string m);
    pulse(1'h0, src);
    `CHK(regOut, exp[0], m)
    if (idle) begin
      readCtrl = '{shiftNotLoad: 1'h1, loadSource: ~src};
      step(10);
      `CHK(regOut, exp[0], "moved without readout clock")
    end
    for (int i = 1; i < 32; i++) begin
      pulse(1'h1, ~src);
      `CHK(regOut, exp[i], m)
    end
  endtask : readSig

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic tPass();
    `CHK(regOut, 1'h0, "serial out after reset")
    waitFor(1'b0, k);
    `CHK(passDone, 1'h1, "no pass completion")
    step(1);
    `CHK(passDone, 1'h0, "completion longer than a cycle")
    waitFor(1'b0, k);
    `CHK(k, PASS - 1, "pass spacing")
    `CHK(errSeen, 1'h0, "error on clean memory")
  endtask : tPass

  task automatic tRead();
    readSig(1'h1, sigOf(1'h0), 1'b1, "clean signature");
  endtask : tRead

  task automatic tErr();
    flip = 1'h1;
    waitFor(1'b1, k);
    `CHK(errSeen, 1'h1, "flip not flagged")
    step(PASS + 2);
    readSig(1'h1, sigOf(1'h1), 1'b0, "calculated signature");
    readSig(1'h0, sigOf(1'h0), 1'b1, "expected value");
    `CHK(errSeen, 1'h1, "error flag dropped")
    reconfigReqN = 1'h0;
    flip = 1'h0;
    step(4);
    reconfigReqN = 1'h1;
    step(3 * PASS);
    `CHK(errSeen, 1'h0, "error after reconfiguration")
    readSig(1'h1, sigOf(1'h0), 1'b0, "repaired signature");
  endtask : tErr

  task automatic conclude();
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  initial begin
    readClk = 1'h0;
    readCtrl = CCSR_CTRL_RST;
    reconfigReqN = 1'h1;
    flip = 1'h0;
    expectedCrc = sigOf(1'h0);
    step(8);
    reset = 1'h0;
    step(3);
    tPass();
    tRead();
    tErr();
    conclude();
  end

  // Four readouts of about 360 cycles each, with ample margin
  initial begin
    repeat (6000) @(posedge ref_clk);
    n_errors++;
    conclude();
  end
endmodule : config_crc_signature_readout_test

`default_nettype wire
